// *** logic/cmb_map.svh ***
// Offsets, offset range limits and reset values of the move/bank execution block
// Assumes inclusion by bare name from design files
`ifndef CMB_MAP_SVH
`define CMB_MAP_SVH
`define CMB_W_RST        8'h00
`define CMB_BANK_RST     5'h00
`define CMB_PTR_RST      16'h0000
`define CMB_ZERO_RST     1'b0
// Pointer target register addresses inside the 7-bit bank offset
`define CMB_TGT0_OFS     7'h00
`define CMB_TGT1_OFS     7'h01
// Pointer byte registers inside the 7-bit bank offset
`define CMB_PTR0_LO_OFS  7'h04
`define CMB_PTR0_HI_OFS  7'h05
`define CMB_PTR1_LO_OFS  7'h06
`define CMB_PTR1_HI_OFS  7'h07
// Bank selector and accumulator readback offsets
`define CMB_BANK_OFS     7'h08
`define CMB_W_OFS        7'h09
`define CMB_OFS_MIN      -32
`define CMB_OFS_MAX      31
`endif

// *** logic/cmb_pkg.sv ***
// Types shared by the move/bank execution block
// Assumes no other package
package cmb_pkg;
  typedef enum logic [2:0] {
    CMB_OP_NONE = 3'b000,
    CMB_OP_OR   = 3'b001,
    CMB_OP_COPY = 3'b010,
    CMB_OP_LDI  = 3'b011,
    CMB_OP_BANK = 3'b100
  } cmb_op_e;
  typedef enum logic [1:0] {
    CMB_UPD_PREINC  = 2'b00,
    CMB_UPD_PREDEC  = 2'b01,
    CMB_UPD_POSTINC = 2'b10,
    CMB_UPD_POSTDEC = 2'b11
  } cmb_upd_e;
  typedef enum logic [1:0] {
    CMB_ST_IDLE  = 2'b00,
    CMB_ST_READ  = 2'b01,
    CMB_ST_WRITE = 2'b10
  } cmb_state_e;
endpackage

// *** logic/cmb_ptr_alu.sv ***
// Effective address and pointer update for the indirect load
// Assumes a pure combinational use by the execution core
`timescale 1ns/1ps
module cmb_ptr_alu #(
  parameter int PW = 16
) (
  // Operands
  input  wire logic [PW-1:0] i_ptr,
  input  wire logic [1:0]    i_upd_sel,
  input  wire logic          i_rel_mode,
  input  wire logic [5:0]    i_offset,
  // Results
  output logic      [PW-1:0] o_eff_addr,
  output logic      [PW-1:0] o_next_ptr
);
  // Modulo arithmetic gives wraparound for free
  wire logic [PW-1:0] ptr_inc = i_ptr + PW'(1); // RL8
  wire logic [PW-1:0] ptr_dec = i_ptr - PW'(1); // RL8
  wire logic [PW-1:0] ptr_rel = i_ptr + {{(PW-6){i_offset[5]}}, i_offset}; // RL4
  wire logic [PW-1:0] mode_addr = (i_upd_sel == cmb_pkg::CMB_UPD_PREINC) ? ptr_inc :
                                  (i_upd_sel == cmb_pkg::CMB_UPD_PREDEC) ? ptr_dec : i_ptr; // RL5
  wire logic [PW-1:0] mode_next = i_upd_sel[0] ? ptr_dec : ptr_inc; // RL6
  assign o_eff_addr = i_rel_mode ? ptr_rel : mode_addr; // RL4
  assign o_next_ptr = i_rel_mode ? i_ptr : mode_next; // RL6
endmodule

// *** logic/cmb_zero_flag.sv ***
// Null-result status bit with its own update strobe
// Assumes one clock and synchronous active-low reset
`timescale 1ns/1ps
`include "cmb_map.svh"
module cmb_zero_flag #(
  parameter int DW = 8
) (
  // Clock and reset
  input  wire logic          i_core_clk,
  input  wire logic          i_rst_n,
  // Update
  input  wire logic          i_upd,
  input  wire logic [DW-1:0] i_value,
  // Flag
  output logic               o_zero
);
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      o_zero <= `CMB_ZERO_RST;
    end else if (i_upd) begin
      o_zero <= (i_value == '0);
    end
  end
endmodule

// *** logic/cmb_core.sv ***
// Execution of OR-literal, copy-operand, indirect load and bank literal
// Assumes a data space that answers a read in the same cycle as the read strobe
// What this block does
// RL1 - OR immediate into accumulator
// RL2 - Copy operand to accumulator or back
// RL3 - Copy operand updates zero flag
// RL4 - Effective address: plus one, minus one, pointer unchanged, offset
// RL5 - Update select decodes pre/post inc/dec
// RL6 - Pointer ends incremented, decremented or unchanged
// RL7 - Pointer targets redirect to pointer address
// RL8 - Pointers wrap modulo 16 bits
// RL9 - Bank literal loads selector, status untouched
// RL10 - Indirect load picks pointer, sets zero
`timescale 1ns/1ps
`include "cmb_map.svh"
module cmb_core #(
  parameter int AW = 16,
  parameter int DW = 8
) (
  // Clock and reset
  input  wire logic          i_core_clk,
  input  wire logic          i_rst_n,
  // Instruction issue
  input  wire logic          i_issue,
  input  wire logic [2:0]    i_op,
  input  wire logic [7:0]    i_imm,
  input  wire logic [6:0]    i_file_ofs,
  input  wire logic          i_dest_sel,
  input  wire logic          i_ptr_idx,
  input  wire logic [1:0]    i_ptr_update_sel,
  input  wire logic          i_rel_mode,
  output logic               o_busy,
  output logic               o_done,
  // Data space
  output logic      [AW-1:0] o_mem_addr,
  output logic               o_mem_rd,
  output logic               o_mem_wr,
  output logic      [DW-1:0] o_mem_wdata,
  input  wire logic [DW-1:0] i_mem_rdata,
  // Register port
  input  wire logic [6:0]    i_reg_addr,
  input  wire logic [DW-1:0] i_reg_wdata,
  input  wire logic          i_reg_wr,
  input  wire logic          i_reg_rd,
  output logic      [DW-1:0] o_reg_rdata,
  // Core state
  output logic      [DW-1:0] o_accum,
  output logic      [4:0]    o_bank_selector,
  output logic               o_zero,
  output logic      [AW-1:0] o_indirect_pointer0,
  output logic      [AW-1:0] o_indirect_pointer1
);
  function automatic logic [AW-1:0] bank_addr(input logic [4:0] bank, input logic [6:0] ofs);
    bank_addr = AW'({bank, ofs});
  endfunction

  cmb_pkg::cmb_state_e state;
  cmb_pkg::cmb_op_e    op_q;
  logic [DW-1:0] accum;
  logic [4:0]    bank_selector;
  logic [AW-1:0] indirect_pointer [2];
  logic          dest_q;
  logic          idx_q;
  logic [AW-1:0] next_ptr_q;
  logic [AW-1:0] addr_q;

  wire cmb_pkg::cmb_op_e op_in = cmb_pkg::cmb_op_e'(i_op);
  wire logic accept  = i_issue && (state == cmb_pkg::CMB_ST_IDLE);
  wire logic is_tgt0 = (i_file_ofs == `CMB_TGT0_OFS);
  wire logic is_tgt1 = (i_file_ofs == `CMB_TGT1_OFS);
  wire logic is_tgt  = is_tgt0 || is_tgt1;
  // Target access goes through the pointer, never to storage
  wire logic [AW-1:0] copy_addr = is_tgt ? indirect_pointer[is_tgt1] :
                                  bank_addr(bank_selector, i_file_ofs); // RL7
  wire logic [AW-1:0] sel_ptr = indirect_pointer[i_ptr_idx]; // RL10
  logic [AW-1:0] eff_addr;
  logic [AW-1:0] ldi_next;

  cmb_ptr_alu #(.PW(AW)) u_ptr_alu (
    .i_ptr      (sel_ptr),
    .i_upd_sel  (i_ptr_update_sel),
    .i_rel_mode (i_rel_mode),
    .i_offset   (i_imm[5:0]),
    .o_eff_addr (eff_addr),
    .o_next_ptr (ldi_next)
  );

  wire logic read_done  = (state == cmb_pkg::CMB_ST_READ);
  wire logic copy_back  = read_done && (op_q == cmb_pkg::CMB_OP_COPY) && dest_q;
  wire logic to_accum   = read_done && !copy_back;
  wire logic or_now     = accept && (op_in == cmb_pkg::CMB_OP_OR);
  wire logic [DW-1:0] or_value = accum | i_imm; // RL1
  wire logic zero_upd   = or_now || read_done; // RL3 RL10
  wire logic [DW-1:0] zero_val = or_now ? or_value : i_mem_rdata;
  wire logic needs_mem  = accept && ((op_in == cmb_pkg::CMB_OP_COPY) || (op_in == cmb_pkg::CMB_OP_LDI));

  cmb_zero_flag #(.DW(DW)) u_zero (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_upd      (zero_upd),
    .i_value    (zero_val),
    .o_zero     (o_zero)
  );

  // Bank and accumulator readback share the register port
  wire logic sw_p0lo = i_reg_wr && (i_reg_addr == `CMB_PTR0_LO_OFS);
  wire logic sw_p0hi = i_reg_wr && (i_reg_addr == `CMB_PTR0_HI_OFS);
  wire logic sw_p1lo = i_reg_wr && (i_reg_addr == `CMB_PTR1_LO_OFS);
  wire logic sw_p1hi = i_reg_wr && (i_reg_addr == `CMB_PTR1_HI_OFS);
  wire logic [DW-1:0] reg_mux =
    (i_reg_addr == `CMB_PTR0_LO_OFS) ? indirect_pointer[0][7:0] :
    (i_reg_addr == `CMB_PTR0_HI_OFS) ? indirect_pointer[0][15:8] :
    (i_reg_addr == `CMB_PTR1_LO_OFS) ? indirect_pointer[1][7:0] :
    (i_reg_addr == `CMB_PTR1_HI_OFS) ? indirect_pointer[1][15:8] :
    (i_reg_addr == `CMB_BANK_OFS)    ? DW'(bank_selector) :
    (i_reg_addr == `CMB_W_OFS)       ? accum : '0;

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state      <= cmb_pkg::CMB_ST_IDLE;
      op_q       <= cmb_pkg::CMB_OP_NONE;
      dest_q     <= 1'b0;
      idx_q      <= 1'b0;
      next_ptr_q <= `CMB_PTR_RST;
      addr_q     <= `CMB_PTR_RST;
    end else begin
      unique case (state)
        cmb_pkg::CMB_ST_IDLE: begin
          if (needs_mem) begin
            state      <= cmb_pkg::CMB_ST_READ;
            op_q       <= op_in;
            dest_q     <= i_dest_sel;
            idx_q      <= i_ptr_idx;
            next_ptr_q <= ldi_next;
            addr_q     <= (op_in == cmb_pkg::CMB_OP_LDI) ? eff_addr : copy_addr;
          end
        end
        cmb_pkg::CMB_ST_READ: begin
          state <= copy_back ? cmb_pkg::CMB_ST_WRITE : cmb_pkg::CMB_ST_IDLE;
        end
        cmb_pkg::CMB_ST_WRITE: begin
          state <= cmb_pkg::CMB_ST_IDLE;
        end
        default: begin
          state <= cmb_pkg::CMB_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      accum         <= `CMB_W_RST;
      bank_selector <= `CMB_BANK_RST;
    end else begin
      if (or_now) begin
        accum <= or_value; // RL1
      end else if (to_accum) begin
        accum <= i_mem_rdata; // RL2
      end
      if (accept && (op_in == cmb_pkg::CMB_OP_BANK)) begin
        bank_selector <= i_imm[4:0]; // RL9
      end
    end
  end

  // Software pointer writes lose to an indirect load finishing on the same pointer in the same cycle
  for (genvar p = 0; p < 2; p++) begin : g_ptr
    always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
        indirect_pointer[p] <= `CMB_PTR_RST;
      end else if (read_done && (op_q == cmb_pkg::CMB_OP_LDI) && (idx_q == 1'(p))) begin
        indirect_pointer[p] <= next_ptr_q; // RL6
      end else if ((p == 0) ? sw_p0lo : sw_p1lo) begin
        indirect_pointer[p][7:0] <= i_reg_wdata;
      end else if ((p == 0) ? sw_p0hi : sw_p1hi) begin
        indirect_pointer[p][15:8] <= i_reg_wdata;
      end
    end
  end

  logic [DW-1:0] wdata_q;
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      wdata_q     <= '0;
      o_reg_rdata <= '0;
    end else begin
      if (copy_back) begin
        wdata_q <= i_mem_rdata; // RL2
      end
      if (i_reg_rd) begin
        o_reg_rdata <= reg_mux;
      end
    end
  end

  assign o_mem_addr          = addr_q;
  // Read strobe marks the cycle in which rdata is taken
  assign o_mem_rd            = read_done;
  assign o_mem_wr            = (state == cmb_pkg::CMB_ST_WRITE);
  assign o_mem_wdata         = wdata_q;
  assign o_busy              = (state != cmb_pkg::CMB_ST_IDLE);
  assign o_done              = (read_done && !copy_back) || o_mem_wr || (accept && !needs_mem);
  assign o_accum             = accum;
  assign o_bank_selector     = bank_selector;
  assign o_indirect_pointer0 = indirect_pointer[0];
  assign o_indirect_pointer1 = indirect_pointer[1];

  a_or_result: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    or_now |=> (accum == $past(or_value))) else $error("OR result wrong"); // RL1
  a_copy_accum: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (to_accum && op_q == cmb_pkg::CMB_OP_COPY) |=> (accum == $past(i_mem_rdata)))
    else $error("Copy to accumulator wrong"); // RL2
  a_copy_zero: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    read_done |=> (o_zero == ($past(i_mem_rdata) == 8'h00))) else $error("Zero flag wrong"); // RL3
  a_ldi_addr: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (needs_mem && op_in == cmb_pkg::CMB_OP_LDI && i_rel_mode) |=>
    (addr_q == $past(sel_ptr) + {{10{$past(i_imm[5])}}, $past(i_imm[5:0])})) else $error("Offset address wrong"); // RL4
  a_pre_inc: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (needs_mem && op_in == cmb_pkg::CMB_OP_LDI && !i_rel_mode && i_ptr_update_sel == 2'b00) |=>
    (addr_q == $past(sel_ptr) + 16'h0001)) else $error("Preincrement address wrong"); // RL5
  sequence s_ldi_issue;
    needs_mem && op_in == cmb_pkg::CMB_OP_LDI && !i_rel_mode && i_ptr_update_sel[0];
  endsequence
  a_ptr_dec: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    s_ldi_issue |=> ##1 (indirect_pointer[idx_q] == $past(sel_ptr, 2) - 16'h0001))
    else $error("Decrement update wrong"); // RL6 RL8
  a_tgt_redirect: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (needs_mem && op_in == cmb_pkg::CMB_OP_COPY && is_tgt0) |=> (addr_q == $past(indirect_pointer[0])))
    else $error("Target not redirected"); // RL7
  a_bank_load: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (accept && op_in == cmb_pkg::CMB_OP_BANK) |=> (bank_selector == $past(i_imm[4:0])) && $stable(o_zero))
    else $error("Bank load wrong"); // RL9
endmodule

// *** verif/testbench.sv ***
// Self-checking bench for the move/bank execution core
// Assumes cmb_core with a data space that answers combinationally from o_mem_addr
`timescale 1ns/1ps
module testbench;
  logic        i_core_clk, i_rst_n, i_issue, i_dest_sel, i_ptr_idx, i_rel_mode, i_reg_wr, i_reg_rd;
  logic [2:0]  i_op;
  logic [7:0]  i_imm, i_reg_wdata, i_mem_rdata, o_mem_wdata, o_reg_rdata, o_accum;
  logic [6:0]  i_file_ofs, i_reg_addr;
  logic [1:0]  i_ptr_update_sel;
  logic        o_busy, o_done, o_mem_rd, o_mem_wr, o_zero;
  logic [15:0] o_mem_addr, o_indirect_pointer0, o_indirect_pointer1;
  logic [4:0]  o_bank_selector;
  int          err_total, compares;
  logic [7:0]  exp_acc, got_wdata, rd_val;
  logic        exp_z, got_wr, got_rd, got_busy;
  logic [15:0] got_addr;

  cmb_core dut_u (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_issue(i_issue), .i_op(i_op), .i_imm(i_imm),
    .i_file_ofs(i_file_ofs), .i_dest_sel(i_dest_sel), .i_ptr_idx(i_ptr_idx), .i_ptr_update_sel(i_ptr_update_sel),
    .i_rel_mode(i_rel_mode), .o_busy(o_busy), .o_done(o_done), .o_mem_addr(o_mem_addr), .o_mem_rd(o_mem_rd),
    .o_mem_wr(o_mem_wr), .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .o_accum(o_accum), .o_bank_selector(o_bank_selector), .o_zero(o_zero),
    .o_indirect_pointer0(o_indirect_pointer0), .o_indirect_pointer1(o_indirect_pointer1));

  // Data space contents derived from the address; 0x005a reads as zero
  function automatic logic [7:0] mem_val(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction
  assign i_mem_rdata = mem_val(o_mem_addr);

  always #12.5 i_core_clk = ~i_core_clk;

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_reg_wr <= 1'b1; i_reg_addr <= a; i_reg_wdata <= d;
    @(posedge i_core_clk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [6:0] a);
    @(posedge i_core_clk);
    i_reg_rd <= 1'b1; i_reg_addr <= a;
    @(posedge i_core_clk);
    i_reg_rd <= 1'b0;
    @(negedge i_core_clk);
    rd_val = o_reg_rdata;
  endtask

  // Holds issue for one taken edge, then waits a bounded time for completion
  task automatic run_op(input logic [2:0] op, input logic [7:0] imm, input logic [6:0] ofs, input logic dest,
                        input logic idx, input logic [1:0] upd, input logic rel);
    logic seen;
    seen = 1'b0;
    @(posedge i_core_clk);
    i_issue <= 1'b1; i_op <= op; i_imm <= imm; i_file_ofs <= ofs;
    i_dest_sel <= dest; i_ptr_idx <= idx; i_ptr_update_sel <= upd; i_rel_mode <= rel;
    for (int n = 0; n < 8 && !seen; n++) begin
      @(negedge i_core_clk);
      if (o_done === 1'b1) begin
        seen = 1'b1; got_wr = o_mem_wr; got_addr = o_mem_addr; got_wdata = o_mem_wdata;
        got_rd = o_mem_rd; got_busy = o_busy;
      end
      @(posedge i_core_clk);
      i_issue <= 1'b0;
    end
    @(negedge i_core_clk);
    chk("done", 16'h0001, {15'h0000, seen});
    chk("accum", {8'h00, exp_acc}, {8'h00, o_accum});
    chk("zero", {15'h0000, exp_z}, {15'h0000, o_zero});
  endtask

  task automatic t_reset();
    chk("accum", 16'h0000, {8'h00, o_accum});
    chk("bank", 16'h0000, {11'h000, o_bank_selector});
    chk("zero", 16'h0000, {15'h0000, o_zero});
    chk("ptr0", 16'h0000, o_indirect_pointer0);
    chk("ptr1", 16'h0000, o_indirect_pointer1);
    $display("TB: test reset done");
  endtask

  task automatic t_or_bank();
    exp_acc = 8'h00; exp_z = 1'b1;
    run_op(3'h1, 8'h00, 7'h00, 1'b0, 1'b0, 2'b00, 1'b0);
    chk("or_busy", 16'h0000, {15'h0000, got_busy});
    run_op(3'h4, 8'h1f, 7'h00, 1'b0, 1'b0, 2'b00, 1'b0);
    chk("bank", 16'h001f, {11'h000, o_bank_selector});
    exp_acc = 8'h81; exp_z = 1'b0;
    run_op(3'h1, 8'h81, 7'h00, 1'b0, 1'b0, 2'b00, 1'b0);
    exp_acc = 8'hc3;
    run_op(3'h1, 8'h42, 7'h00, 1'b0, 1'b0, 2'b00, 1'b0);
    run_op(3'h4, 8'h05, 7'h00, 1'b0, 1'b0, 2'b00, 1'b0);
    chk("bank", 16'h0005, {11'h000, o_bank_selector});
    $display("TB: test or_bank done");
  endtask

  task automatic t_regs();
    reg_wr(7'h04, 8'hff); reg_wr(7'h05, 8'hff); reg_wr(7'h06, 8'h59); reg_wr(7'h07, 8'h00);
    reg_wr(7'h7f, 8'haa);
    chk("ptr0", 16'hffff, o_indirect_pointer0);
    chk("ptr1", 16'h0059, o_indirect_pointer1);
    chk("bank", 16'h0005, {11'h000, o_bank_selector});
    reg_rd(7'h05); chk("rd_ptr0_hi", 16'h00ff, {8'h00, rd_val});
    reg_rd(7'h08); chk("rd_bank", 16'h0005, {8'h00, rd_val});
    reg_rd(7'h09); chk("rd_accum", 16'h00c3, {8'h00, rd_val});
    $display("TB: test regs done");
  endtask

  task automatic do_load(input logic idx, input logic [1:0] upd, input logic rel, input logic [5:0] off,
                         input logic [15:0] p);
    logic [15:0] eff, np;
    eff = rel ? p + {{10{off[5]}}, off} : (upd == 2'b00) ? p + 16'h0001 : (upd == 2'b01) ? p - 16'h0001 : p;
    np = rel ? p : upd[0] ? p - 16'h0001 : p + 16'h0001;
    exp_acc = mem_val(eff); exp_z = (exp_acc == 8'h00);
    run_op(3'h3, {2'b00, off}, 7'h00, 1'b0, idx, upd, rel);
    chk("load_addr", eff, got_addr);
    chk("ptr", np, idx ? o_indirect_pointer1 : o_indirect_pointer0);
    chk("load_rd", 16'h0001, {15'h0000, got_rd});
    chk("load_busy", 16'h0001, {15'h0000, got_busy});
  endtask

  task automatic t_load();
    do_load(1'b0, 2'b00, 1'b0, 6'h00, 16'hffff);
    do_load(1'b0, 2'b01, 1'b0, 6'h00, 16'h0000);
    do_load(1'b0, 2'b10, 1'b0, 6'h00, 16'hffff);
    do_load(1'b0, 2'b11, 1'b0, 6'h00, 16'h0000);
    do_load(1'b1, 2'b00, 1'b0, 6'h00, 16'h0059);
    chk("ptr0_kept", 16'hffff, o_indirect_pointer0);
    do_load(1'b1, 2'b00, 1'b1, 6'h20, 16'h005a);
    reg_wr(7'h06, 8'h10); reg_wr(7'h07, 8'h00);
    do_load(1'b1, 2'b00, 1'b1, 6'h20, 16'h0010);
    do_load(1'b1, 2'b11, 1'b1, 6'h1f, 16'h0010);
    $display("TB: test load done");
  endtask

  task automatic do_copy(input logic [6:0] ofs, input logic dest, input logic [15:0] a);
    logic [7:0] v;
    v = mem_val(a);
    if (!dest) exp_acc = v;
    exp_z = (v == 8'h00);
    run_op(3'h2, 8'h00, ofs, dest, 1'b0, 2'b00, 1'b0);
    chk("copy_addr", a, got_addr);
    chk("copy_wr", {15'h0000, dest}, {15'h0000, got_wr});
    chk("copy_rd", {15'h0000, ~dest}, {15'h0000, got_rd});
    chk("copy_busy", 16'h0001, {15'h0000, got_busy});
    if (dest) chk("copy_wdata", {8'h00, v}, {8'h00, got_wdata});
  endtask

  task automatic t_copy();
    run_op(3'h4, 8'h05, 7'h00, 1'b0, 1'b0, 2'b00, 1'b0);
    do_copy(7'h22, 1'b0, 16'h02a2);
    run_op(3'h4, 8'h00, 7'h00, 1'b0, 1'b0, 2'b00, 1'b0);
    do_copy(7'h5a, 1'b1, 16'h005a);
    do_copy(7'h00, 1'b0, 16'hffff);
    do_copy(7'h01, 1'b1, 16'h0010);
    $display("TB: test copy done");
  endtask

  task automatic finish_test();
    $display("TB: checks %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    i_core_clk = 1'b0; i_rst_n = 1'b0; i_issue = 1'b0; i_op = 3'h0; i_imm = 8'h00; i_file_ofs = 7'h00;
    i_dest_sel = 1'b0; i_ptr_idx = 1'b0; i_ptr_update_sel = 2'b00; i_rel_mode = 1'b0;
    i_reg_wr = 1'b0; i_reg_rd = 1'b0; i_reg_addr = 7'h00; i_reg_wdata = 8'h00;
    err_total = 0; compares = 0;
    repeat (6) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    @(negedge i_core_clk);
    t_reset();
    t_or_bank();
    t_regs();
    t_load();
    t_copy();
    finish_test();
  end

  // Whole run takes well under a thousand cycles
  initial begin
    #(25 * 5000);
    err_total++;
    finish_test();
  end
endmodule
